// *** uart_cfg_pkg.sv ***
package uart_cfg_pkg;
	// wishbone register byte addresses
	localparam logic [7:0] ADDR_TX_LEVEL   = 8'h00;
	localparam logic [7:0] ADDR_RX_LEVEL   = 8'h04;
	localparam logic [7:0] ADDR_FLOW_HIGH  = 8'h08;
	localparam logic [7:0] ADDR_FLOW_LOW   = 8'h0C;
	localparam logic [7:0] ADDR_PRESCALE   = 8'h10;
	localparam logic [7:0] ADDR_TURNAROUND = 8'h14;
	localparam logic [7:0] ADDR_CONTROL    = 8'h18;
	localparam logic [7:0] ADDR_STATUS     = 8'h1C;
	localparam logic [7:0] ADDR_IRQ_STAT   = 8'h20;
	localparam logic [7:0] ADDR_IRQ_EN     = 8'h24;
	localparam logic [7:0] ADDR_IRQ_CLR    = 8'h28;
	// reset values
	localparam logic [7:0] LEVEL_RST       = 8'h00;
	localparam logic [3:0] PRESCALE_RST    = 4'h0;
	// control register fields
	localparam int CTL_BIG_FIFO  = 0;
	localparam int CTL_NINE_BIT  = 1;
	localparam int CTL_AUTO_RTS  = 2;
	localparam int CTL_DIR_SEL   = 3;
	localparam int CTL_W         = 4;
	// interrupt event bit positions
	localparam int EV_TX_LEVEL   = 0;
	localparam int EV_RX_LEVEL   = 1;
	localparam int EV_TURNED     = 2;
	localparam int EV_W          = 3;
	// level decode
	localparam logic [7:0] LEVEL_MIN   = 8'h01;
	localparam logic [7:0] LEVEL_MAX   = 8'h80;
	localparam int         COUNT_W     = 8;
endpackage

// *** level_decode.sv ***
`timescale 1ns/1ps
// decodes a level code into an entry count: 0 and 1 both mean 1, caps at 128
module level_decode (
	// code in
	input  wire logic [7:0] code,
	// decoded level out
	output logic      [7:0] level
);
	import uart_cfg_pkg::*;
	// zero maps to one entry, anything above 128 clamps
	always_comb begin
		if (code < LEVEL_MIN) begin
			level = LEVEL_MIN;
		end else if (code > LEVEL_MAX) begin
			level = LEVEL_MAX;
		end else begin
			level = code;
		end
	end
endmodule // level_decode

// *** uart_cfg_core.sv ***
// Decided for this implementation: the Wishbone register port and the address map.
`timescale 1ns/1ps
module uart_cfg_core (
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        arst_n,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// fifo fill levels and legacy levels from the uart core
	input  wire logic [7:0]  tx_fill,
	input  wire logic [7:0]  rx_fill,
	input  wire logic [7:0]  legacy_tx_level,
	input  wire logic [7:0]  legacy_rx_level,
	input  wire logic [7:0]  legacy_flow_high,
	input  wire logic [7:0]  legacy_flow_low,
	// transmitter timing
	input  wire logic        bit_tick,
	input  wire logic        tx_shift_done,
	// outputs
	output logic             tx_level_irq,
	output logic             rx_level_irq,
	output logic             flow_stop,
	output logic             rts_n,
	output logic             dtr_n,
	output logic      [3:0]  clock_prescale,
	output logic             irq
);
	import uart_cfg_pkg::*;

	logic [7:0]       tx_fifo_irq_level_ff;
	logic [7:0]       rx_fifo_irq_level_ff;
	logic [7:0]       flow_high_threshold_ff;
	logic [7:0]       flow_low_threshold_ff;
	logic [3:0]       clock_prescale_value_ff;
	logic [7:0]       line_turnaround_delay_ff;
	logic [CTL_W-1:0] control_ff;
	logic [EV_W-1:0]  irq_stat_ff;
	logic [EV_W-1:0]  irq_en_ff;
	logic [7:0]       turn_cnt_ff;
	logic             turn_busy_ff;
	logic             dir_drive_ff;
	logic             turned_pulse;
	logic [7:0]       tx_dec;
	logic [7:0]       rx_dec;
	logic [7:0]       high_dec;
	logic [7:0]       low_dec;
	logic [7:0]       tx_eff;
	logic [7:0]       rx_eff;
	logic [7:0]       high_eff;
	logic [7:0]       low_eff;
	logic             req;
	logic             wr;
	logic [31:0]      rd_data;

	// every assertion below runs on the core clock and sleeps during reset
	default clocking core_cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	// decoders for the four level registers
	level_decode u_tx_dec (
		.code  (tx_fifo_irq_level_ff),
		.level (tx_dec)
	);
	level_decode u_rx_dec (
		.code  (rx_fifo_irq_level_ff),
		.level (rx_dec)
	);
	level_decode u_high_dec (
		.code  (flow_high_threshold_ff),
		.level (high_dec)
	);
	level_decode u_low_dec (
		.code  (flow_low_threshold_ff),
		.level (low_dec)
	);

	// programmable levels only in big-fifo mode
	assign tx_eff   = control_ff[CTL_BIG_FIFO] ? tx_dec : legacy_tx_level;
	assign rx_eff   = control_ff[CTL_BIG_FIFO] ? rx_dec : legacy_rx_level;
	assign high_eff = control_ff[CTL_BIG_FIFO] ? high_dec
		: legacy_flow_high;
	assign low_eff  = control_ff[CTL_BIG_FIFO] ? low_dec
		: legacy_flow_low;

	// bus request decode; ack one cycle after request, dropped next cycle
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr  = req && wb_we_i && wb_sel_i[0];

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req;
		end
	end

	// level and config registers
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_fifo_irq_level_ff     <= LEVEL_RST;
			rx_fifo_irq_level_ff     <= LEVEL_RST;
			flow_high_threshold_ff   <= LEVEL_RST;
			flow_low_threshold_ff    <= LEVEL_RST;
			clock_prescale_value_ff  <= PRESCALE_RST;
			line_turnaround_delay_ff <= LEVEL_RST;
			control_ff               <= '0;
			irq_en_ff                <= '0;
		end else if (wr) begin
			unique case (wb_adr_i)
				ADDR_TX_LEVEL:   tx_fifo_irq_level_ff <= wb_dat_i[7:0];
				ADDR_RX_LEVEL:   rx_fifo_irq_level_ff <= wb_dat_i[7:0];
				ADDR_FLOW_HIGH:  flow_high_threshold_ff <= wb_dat_i[7:0];
				ADDR_FLOW_LOW:   flow_low_threshold_ff <= wb_dat_i[7:0];
				ADDR_PRESCALE:   clock_prescale_value_ff <= wb_dat_i[3:0];
				ADDR_TURNAROUND: line_turnaround_delay_ff <= wb_dat_i[7:0];
				ADDR_CONTROL:    control_ff <= wb_dat_i[CTL_W-1:0];
				ADDR_IRQ_EN:     irq_en_ff <= wb_dat_i[EV_W-1:0];
				default: ;
			endcase
		end
	end

	// read mux; unmapped and write-only read zero
	always_comb begin
		rd_data = '0;
		unique case (wb_adr_i)
			ADDR_TX_LEVEL:   rd_data[7:0] = tx_fifo_irq_level_ff;
			ADDR_RX_LEVEL:   rd_data[7:0] = rx_fifo_irq_level_ff;
			ADDR_FLOW_HIGH:  rd_data[7:0] = flow_high_threshold_ff;
			ADDR_FLOW_LOW:   rd_data[7:0] = flow_low_threshold_ff;
			ADDR_PRESCALE:   rd_data[3:0] = clock_prescale_value_ff;
			ADDR_TURNAROUND: rd_data[7:0] = line_turnaround_delay_ff;
			ADDR_CONTROL:    rd_data[CTL_W-1:0] = control_ff;
			ADDR_STATUS:     rd_data[7:0] = turn_cnt_ff;
			ADDR_IRQ_STAT:   rd_data[EV_W-1:0] = irq_stat_ff;
			ADDR_IRQ_EN:     rd_data[EV_W-1:0] = irq_en_ff;
			default:         rd_data = '0;
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			wb_dat_o <= '0;
		end else if (req && !wb_we_i) begin
			wb_dat_o <= rd_data;
		end
	end

	// fifo threshold comparisons
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_level_irq <= 1'b0;
			rx_level_irq <= 1'b0;
		end else begin
			tx_level_irq <= tx_fill <= tx_eff;
			rx_level_irq <= rx_fill >= rx_eff;
		end
	end

	// flow stop with hysteresis between high and low thresholds
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flow_stop <= 1'b0;
		end else if (rx_fill >= high_eff) begin
			flow_stop <= 1'b1;
		end else if (rx_fill < low_eff) begin
			flow_stop <= 1'b0;
		end
	end

	// turn-around countdown in bit periods
	// a fresh load in the same cycle restarts the count: no done event then
	assign turned_pulse = turn_busy_ff && bit_tick
		&& (turn_cnt_ff == '0)
		&& !(control_ff[CTL_NINE_BIT] && tx_shift_done);
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			turn_cnt_ff  <= '0;
			turn_busy_ff <= 1'b0;
			dir_drive_ff <= 1'b0;
		end else if (control_ff[CTL_NINE_BIT] && tx_shift_done) begin
			turn_cnt_ff  <= line_turnaround_delay_ff;
			turn_busy_ff <= 1'b1;
			dir_drive_ff <= 1'b1;
		end else if (turn_busy_ff && bit_tick) begin
			if (turn_cnt_ff == '0) begin
				turn_busy_ff <= 1'b0;
				dir_drive_ff <= 1'b0;
			end else begin
				turn_cnt_ff <= turn_cnt_ff - 8'h01;
			end
		end
	end

	// direction pins: active low; low releases driver to receive
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
		end else if (control_ff[CTL_NINE_BIT]) begin
			rts_n <= control_ff[CTL_DIR_SEL] ? 1'b1 : dir_drive_ff;
			dtr_n <= control_ff[CTL_DIR_SEL] ? dir_drive_ff : 1'b1;
		end else begin
			rts_n <= control_ff[CTL_AUTO_RTS] && flow_stop;
			dtr_n <= 1'b1;
		end
	end

	// sticky status; set wins over clear
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_stat_ff <= '0;
		end else begin
			logic [EV_W-1:0] set_v;
			logic [EV_W-1:0] clr_v;
			set_v = '0;
			clr_v = '0;
			set_v[EV_TX_LEVEL] = tx_fill <= tx_eff;
			set_v[EV_RX_LEVEL] = rx_fill >= rx_eff;
			set_v[EV_TURNED]   = turned_pulse;
			if (wr && wb_adr_i == ADDR_IRQ_CLR) begin
				clr_v = wb_dat_i[EV_W-1:0];
			end
			irq_stat_ff <= (irq_stat_ff & ~clr_v) | set_v;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_ff & irq_en_ff);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			clock_prescale <= PRESCALE_RST;
		end else begin
			clock_prescale <= clock_prescale_value_ff;
		end
	end

	// assertions; steps of the multi-cycle behaviours as named sequences
	sequence s_load;
		control_ff[CTL_NINE_BIT] && tx_shift_done;
	endsequence
	sequence s_release;
		turned_pulse;
	endsequence
	sequence s_prescale_wr;
		wr && wb_adr_i == ADDR_PRESCALE;
	endsequence
	sequence s_bus_take;
		req;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence

	// bus answers one cycle after the take and drops straight after
	AST_ACK: assert property (
		s_bus_take |=> s_ack_pulse)
		else $error("ack not a single pulse");

	// threshold flags follow the comparison one cycle later;
	// the first edge after reset still shows the reset value
	AST_TX_IRQ: assert property (
		$past(arst_n) |-> tx_level_irq == $past(tx_fill <= tx_eff))
		else $error("tx level irq mismatch");
	AST_DEC_ZERO: assert property (
		tx_fifo_irq_level_ff == 8'h00 |-> tx_dec == 8'h01)
		else $error("code zero not one entry");
	AST_DEC_MAX: assert property (
		tx_fifo_irq_level_ff >= LEVEL_MAX |-> tx_dec == LEVEL_MAX)
		else $error("top code not 128 entries");
	AST_RX_IRQ: assert property (
		$past(arst_n) |-> rx_level_irq == $past(rx_fill >= rx_eff))
		else $error("rx level irq mismatch");

	// flow control: set at high, clear below low, hold in between
	AST_FLOW_STOP: assert property (
		rx_fill >= high_eff |=> flow_stop)
		else $error("flow not stopped");
	AST_FLOW_GO: assert property (
		rx_fill < low_eff && rx_fill < high_eff |=> !flow_stop)
		else $error("flow not restarted");
	AST_FLOW_HOLD: assert property (
		rx_fill >= low_eff && rx_fill < high_eff
		|=> flow_stop == $past(flow_stop))
		else $error("flow state moved inside hysteresis");

	// level source follows the fifo mode
	AST_LEGACY: assert property (
		!control_ff[CTL_BIG_FIFO] |-> rx_eff == legacy_rx_level)
		else $error("legacy level not used");
	AST_BIG: assert property (
		control_ff[CTL_BIG_FIFO] |-> rx_eff == rx_dec && tx_eff == tx_dec)
		else $error("programmed level not used");

	// prescaler reaches its pin two edges after the write
	AST_PRESCALE: assert property (
		s_prescale_wr |=> ##1
		clock_prescale == $past(wb_dat_i[3:0], 2))
		else $error("prescale not applied");

	// turn-around: load, count on bit ticks, release the driver
	AST_LOAD: assert property (
		s_load |=> turn_busy_ff
		&& turn_cnt_ff == $past(line_turnaround_delay_ff))
		else $error("turnaround not loaded");
	AST_RELEASE: assert property (
		s_release |=> !dir_drive_ff && !turn_busy_ff)
		else $error("direction not released");
	AST_DIR_RTS: assert property (
		control_ff[CTL_NINE_BIT] && !control_ff[CTL_DIR_SEL]
		|=> rts_n == $past(dir_drive_ff) && dtr_n)
		else $error("rts pin does not follow direction");
	AST_DIR_DTR: assert property (
		control_ff[CTL_NINE_BIT] && control_ff[CTL_DIR_SEL]
		|=> dtr_n == $past(dir_drive_ff) && rts_n)
		else $error("dtr pin does not follow direction");
	AST_TICK: assert property (
		turn_busy_ff && !bit_tick && !tx_shift_done |=> $stable(turn_cnt_ff))
		else $error("count moved without bit tick");
	AST_TURNED_STICKY: assert property (
		s_release |=> irq_stat_ff[EV_TURNED])
		else $error("turn-around event lost");

	// request-to-send outside the nine-bit mode
	AST_AUTO_RTS: assert property (
		!control_ff[CTL_NINE_BIT]
		|=> rts_n == $past(control_ff[CTL_AUTO_RTS] && flow_stop) && dtr_n)
		else $error("request-to-send wrong");

	// sticky status and the level interrupt output
	AST_RX_STICKY: assert property (
		rx_fill >= rx_eff |=> irq_stat_ff[EV_RX_LEVEL])
		else $error("rx level event lost");
	AST_IRQ_OUT: assert property (
		$past(arst_n) |-> irq == $past(|(irq_stat_ff & irq_en_ff)))
		else $error("irq output wrong");
endmodule // uart_cfg_core

// *** uart_side_model.sv ***
`timescale 1ns/1ps
// stands in for the uart core: fill counts, bit ticks, shift-done pulses
module uart_side_model (
	// clock
	input  wire logic       core_clk,
	// toward the block
	output logic      [7:0] tx_fill,
	output logic      [7:0] rx_fill,
	output logic      [7:0] legacy_lvl,
	output logic            bit_tick,
	output logic            tx_shift_done
);
	logic [1:0] div_ff;

	// fifos start empty, legacy trigger level fixed at eight
	initial begin
		tx_fill = 8'h00;
		rx_fill = 8'h00;
		legacy_lvl = 8'h08;
		tx_shift_done = 1'b0;
		div_ff = 2'h0;
	end
	// one bit period every four core clocks, running free
	always @(posedge core_clk) begin
		div_ff <= div_ff + 2'h1;
	end
	assign bit_tick = (div_ff == 2'h3);
	// new fill counts, then let the registered flags settle
	task automatic fill(input logic [7:0] t, input logic [7:0] r);
		tx_fill <= t;
		rx_fill <= r;
		repeat (3) @(posedge core_clk);
	endtask
	// last bit leaves the shifter: one-cycle pulse
	task automatic shift_out();
		tx_shift_done <= 1'b1;
		@(posedge core_clk);
		tx_shift_done <= 1'b0;
		@(posedge core_clk);
	endtask
endmodule // uart_side_model

// *** test_uart_fifo_levels_rs485_turnaround.sv ***
`timescale 1ns/1ps
// drives the register bus and the model, checks thresholds and turn-around
module test_uart_fifo_levels_rs485_turnaround;
	import uart_cfg_pkg::*;
	logic        core_clk, arst_n, cyc, stb, we, ack, tick, sdone;
	logic        tx_irq, rx_irq, stop, rts_n, dtr_n, irq;
	logic [7:0]  adr, tx_fill, rx_fill, leg;
	logic [3:0]  pres;
	logic [31:0] wdat, dat_o;
	int          bad_count, checks_done;
	logic [7:0]  codes[5] = '{8'h00, 8'h01, 8'h80, 8'h10, 8'hFF};
	logic [7:0]  lvls[5]  = '{8'h01, 8'h01, 8'h80, 8'h10, 8'h80};
	logic [7:0]  addrs[6] = '{ADDR_TX_LEVEL, ADDR_RX_LEVEL, ADDR_FLOW_HIGH,
		ADDR_FLOW_LOW, ADDR_PRESCALE, ADDR_TURNAROUND};

	uart_cfg_core dut (.core_clk(core_clk), .arst_n(arst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.tx_fill(tx_fill), .rx_fill(rx_fill), .legacy_tx_level(leg),
		.legacy_rx_level(leg), .legacy_flow_high(leg),
		.legacy_flow_low(leg), .bit_tick(tick), .tx_shift_done(sdone),
		.tx_level_irq(tx_irq), .rx_level_irq(rx_irq), .flow_stop(stop),
		.rts_n(rts_n), .dtr_n(dtr_n), .clock_prescale(pres), .irq(irq));
	uart_side_model side (.core_clk(core_clk), .tx_fill(tx_fill),
		.rx_fill(rx_fill), .legacy_lvl(leg), .bit_tick(tick),
		.tx_shift_done(sdone));

	// free-running core clock
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	// verdict and end of run
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one classic wishbone cycle, held until ack is sampled
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [31:0] q);
		int n;
		logic hit;
		n = 0;
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= {24'h00_0000, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		hit = (ack === 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge core_clk);
		if (!hit) begin
			chk(32'h0000_0000, 32'h0000_0001);
			finish_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 8'h00, q);
		chk(q & m, e);
	endtask
	// wait for the direction pin to turn the transceiver round
	task automatic wait_rel(input logic use_dtr);
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while ((use_dtr ? dtr_n : rts_n) !== 1'b0 && n < 60);
		chk(32'(n >= 4 && n < 20), 32'h0000_0001);
	endtask

	// main sequence
	initial begin
		arst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0000_0000;
		bad_count = 0;
		checks_done = 0;
		repeat (19) @(posedge core_clk);
		chk(32'({rts_n, dtr_n}), 32'h0000_0003);
		@(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		for (int i = 0; i < 5; i++) rd(addrs[i], 32'hFFFF_FFFF, 0);
		for (int i = 0; i < 6; i++) begin
			if (i != 4) wr(addrs[i], 8'h5A);
			if (i != 4) rd(addrs[i], 32'hFFFF_FFFF, 32'h5A);
		end
		wr(ADDR_PRESCALE, 8'hFF);
		rd(ADDR_PRESCALE, 32'hFFFF_FFFF, 32'h0F);
		chk(32'(pres), 32'h0000_000F);
		wr(8'h40, 8'hFF);
		rd(8'h40, 32'hFFFF_FFFF, 0);
		$display("registers done");
		wr(ADDR_CONTROL, 8'h01);
		for (int i = 0; i < 5; i++) begin
			wr(ADDR_TX_LEVEL, codes[i]);
			wr(ADDR_RX_LEVEL, codes[i]);
			side.fill(lvls[i], lvls[i] - 8'h01);
			chk(32'({tx_irq, rx_irq}), 32'h0000_0002);
			side.fill(lvls[i] + 8'h01, lvls[i]);
			chk(32'({tx_irq, rx_irq}), 32'h0000_0001);
		end
		wr(ADDR_CONTROL, 8'h00);
		wr(ADDR_RX_LEVEL, 8'h80);
		side.fill(8'h08, 8'h08);
		chk(32'({tx_irq, rx_irq}), 32'h0000_0003);
		side.fill(8'h09, 8'h07);
		chk(32'({tx_irq, rx_irq}), 32'h0000_0000);
		$display("levels done");
		wr(ADDR_CONTROL, 8'h05);
		wr(ADDR_FLOW_HIGH, 8'h20);
		wr(ADDR_FLOW_LOW, 8'h08);
		side.fill(8'h00, 8'h20);
		chk(32'({stop, rts_n}), 32'h0000_0003);
		side.fill(8'h00, 8'h10);
		chk(32'({stop, rts_n}), 32'h0000_0003);
		side.fill(8'h00, 8'h07);
		chk(32'({stop, rts_n}), 32'h0000_0000);
		$display("flow control done");
		wr(ADDR_IRQ_EN, 8'h00);
		wr(ADDR_RX_LEVEL, 8'h04);
		side.fill(8'h00, 8'h00);
		wr(ADDR_IRQ_CLR, 8'h07);
		rd(ADDR_IRQ_STAT, 32'h2, 0);
		side.fill(8'h00, 8'h04);
		rd(ADDR_IRQ_STAT, 32'h2, 32'h2);
		chk(32'(irq), 0);
		wr(ADDR_IRQ_EN, 8'h02);
		side.fill(8'h00, 8'h00);
		chk(32'(irq), 32'h0000_0001);
		rd(ADDR_IRQ_STAT, 32'h2, 32'h2);
		wr(ADDR_IRQ_CLR, 8'h02);
		rd(ADDR_IRQ_STAT, 32'h2, 0);
		chk(32'(irq), 0);
		$display("interrupts done");
		for (int d = 0; d < 2; d++) begin
			wr(ADDR_CONTROL, {4'h0, d[0], 3'b010});
			wr(ADDR_TURNAROUND, 8'h03);
			wr(ADDR_IRQ_CLR, 8'h04);
			side.shift_out();
			repeat (4) @(posedge core_clk);
			chk(32'({rts_n, dtr_n}), 32'h0000_0003);
			wait_rel(d[0]);
			chk(32'(d[0] ? rts_n : dtr_n), 32'h0000_0001);
			rd(ADDR_IRQ_STAT, 32'h4, 32'h4);
		end
		$display("turn-around done");
		finish_test();
	end
endmodule // test_uart_fifo_levels_rs485_turnaround
